//--- hbwls_top.sv
/*
 host data-path front end: lane ordering, byte swap, 8/16-bit steering and the
 post-reset initialisation load with its pending output.
 assumes host strobes already synchronous to core_clk_i, one-cycle wide.
*/
`timescale 1ns/1ps
module hbwls_top
    import hbwls_pkg::*;
#(
    parameter int BOOT_WORDS = hbwls_pkg::HBWLS_BOOT_WORDS,
    parameter int PROT_WORDS = hbwls_pkg::HBWLS_PROT_WORDS
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // host side
    input wire hbwls_pkg::hbwls_host_req_s host_req_i,
    input wire logic bus_width_strap_i,
    output hbwls_pkg::hbwls_host_rsp_s host_rsp_o,
    output logic [15:0] host_data_oe_o,
    output logic init_pending_n_o,
    // initialisation source (boot image and protection words)
    output logic load_req_o,
    output logic [15:0] load_addr_o,
    input wire logic load_valid_i,
    input wire logic [15:0] load_data_i,
    // flash array side
    output logic flash_rd_o,
    output logic flash_wr_o,
    output logic [12:0] flash_addr_o,
    output logic [15:0] flash_wdata_o,
    input wire logic [15:0] flash_rdata_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic [PROT_WORDS*16-1:0] prot_state_o
);
    import hbwls_pkg::*;

    localparam int BAW = $clog2(BOOT_WORDS);

    initial begin
        if (BOOT_WORDS < 2 || PROT_WORDS < 1 || BOOT_WORDS + PROT_WORDS > 65536) begin
            $error("hbwls_top: unsupported boot or protection size");
        end
    end

    typedef enum logic [1:0] {HBWLS_S_BOOT, HBWLS_S_PROT, HBWLS_S_DONE} hbwls_init_e;

    // ==========================================================
    // strap capture after reset release
    logic strap_q;
    logic strap_taken_q;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strap_q <= 1'b0;
            strap_taken_q <= 1'b0;
        end else if (clk_en_i && !strap_taken_q) begin
            strap_q <= bus_width_strap_i;
            strap_taken_q <= 1'b1;
        end
    end

    // ==========================================================
    // initialisation load
    hbwls_init_e init_q;
    logic [15:0] ld_cnt_q;
    logic ld_wait_q;
    logic [PROT_WORDS*16-1:0] prot_q;
    logic boot_ld_we;

    assign boot_ld_we = (init_q == HBWLS_S_BOOT) && ld_wait_q && load_valid_i;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            init_q <= HBWLS_S_BOOT;
            ld_cnt_q <= 16'h0000;
            ld_wait_q <= 1'b0;
        end else if (clk_en_i) begin
            unique case (init_q)
                HBWLS_S_BOOT, HBWLS_S_PROT: begin
                    if (!ld_wait_q) begin
                        ld_wait_q <= 1'b1;
                    end else if (load_valid_i) begin
                        ld_wait_q <= 1'b0;
                        if (init_q == HBWLS_S_BOOT && ld_cnt_q == 16'(BOOT_WORDS - 1)) begin
                            init_q <= HBWLS_S_PROT;
                            ld_cnt_q <= 16'h0000;
                        end else if (init_q == HBWLS_S_PROT && ld_cnt_q == 16'(PROT_WORDS - 1)) begin
                            init_q <= HBWLS_S_DONE;
                        end else begin
                            ld_cnt_q <= ld_cnt_q + 16'h0001;
                        end
                    end
                end
                HBWLS_S_DONE: begin
                    ld_wait_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prot_q <= '0;
        end else if (clk_en_i && init_q == HBWLS_S_PROT && ld_wait_q && load_valid_i) begin
            prot_q[ld_cnt_q[$clog2(PROT_WORDS+1)-1:0]*16 +: 16] <= load_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_req_o <= 1'b0;
            load_addr_o <= 16'h0000;
            init_pending_n_o <= 1'b0;
        end else if (clk_en_i) begin
            load_req_o <= (init_q != HBWLS_S_DONE) && !ld_wait_q;
            load_addr_o <= (init_q == HBWLS_S_PROT) ? 16'(BOOT_WORDS) + ld_cnt_q : ld_cnt_q;
            // only the init load drives pending, never flash activity
            init_pending_n_o <= (init_q == HBWLS_S_DONE);
        end
    end

    assign prot_state_o = prot_q;

    // ==========================================================
    // endian control register
    logic [1:0] endian_q;
    logic swap_en;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            endian_q <= HBWLS_ENDIAN_RST;
        end else if (clk_en_i && reg_wr_i && reg_addr_i == HBWLS_ENDIAN_CTRL_OFF) begin
            endian_q <= reg_wdata_i[1:0];
        end
    end
    assign swap_en = endian_q[HBWLS_SWAP_HIGH_POS] && endian_q[HBWLS_SWAP_LOW_POS];

    // ==========================================================
    // access decode
    hbwls_acc_e acc;
    logic ready;
    logic host_rd;
    logic host_wr;
    logic is_boot;
    always_comb begin
        unique case ({host_req_i.addr[0], strap_q})
            2'b01: acc = HBWLS_ACC_WORD;
            2'b00: acc = HBWLS_ACC_EVEN;
            2'b10: acc = HBWLS_ACC_ODD;
            default: acc = HBWLS_ACC_ILLEGAL;
        endcase
    end
    assign ready = (init_q == HBWLS_S_DONE);
    // illegal combination gives no access, it only sets the sticky illegal flag
    assign host_rd = host_req_i.rd && ready && acc != HBWLS_ACC_ILLEGAL;
    assign host_wr = host_req_i.wr && ready && acc != HBWLS_ACC_ILLEGAL;
    assign is_boot = host_req_i.addr[12:11] == 2'b00;

    // host lanes to internal little-endian word
    logic [15:0] wr_word;
    logic [1:0] wr_be;
    always_comb begin
        wr_word = host_req_i.data;
        wr_be = 2'b11;
        if (acc == HBWLS_ACC_WORD && swap_en) begin
            wr_word = {host_req_i.data[7:0], host_req_i.data[15:8]};
        end else if (acc == HBWLS_ACC_EVEN) begin
            wr_word = {8'h00, host_req_i.data[7:0]};
            wr_be = 2'b01;
        end else if (acc == HBWLS_ACC_ODD) begin
            wr_word = {host_req_i.data[7:0], 8'h00};
            wr_be = 2'b10;
        end
    end

    // ==========================================================
    // boot block, true 16-bit memory
    logic [15:0] boot_rdata;
    logic [BAW-1:0] boot_addr;
    assign boot_addr = boot_ld_we ? ld_cnt_q[BAW-1:0] : BAW'(host_req_i.addr[12:1]);

    hbwls_mem #(
        .WIDTH(16),
        .DEPTH(BOOT_WORDS)
    ) u_boot (
        .core_clk_i(core_clk_i),
        .ce_i(clk_en_i),
        .we_i(boot_ld_we || (host_wr && is_boot)),
        .be_i(boot_ld_we ? 2'b11 : wr_be),
        .addr_i(boot_addr),
        .wdata_i(boot_ld_we ? load_data_i : wr_word),
        .rdata_o(boot_rdata)
    );

    // ==========================================================
    // flash area port, word-wide regardless of host width
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flash_rd_o <= 1'b0;
            flash_wr_o <= 1'b0;
            flash_addr_o <= 13'h0000;
            flash_wdata_o <= 16'h0000;
        end else if (clk_en_i) begin
            flash_rd_o <= host_rd && !is_boot;
            flash_wr_o <= host_wr && !is_boot;
            if ((host_rd || host_wr) && !is_boot) begin
                flash_addr_o <= {host_req_i.addr[12:1], 1'b0};
                flash_wdata_o <= wr_word;
            end
        end
    end

    // ==========================================================
    // read return, one cycle after the memory read
    logic rd_p_q;
    logic rd_boot_q;
    hbwls_acc_e rd_acc_q;
    logic [15:0] rd_word;
    logic [15:0] rd_lanes;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_p_q <= 1'b0;
            rd_boot_q <= 1'b0;
            rd_acc_q <= HBWLS_ACC_WORD;
        end else if (clk_en_i) begin
            rd_p_q <= host_rd;
            rd_boot_q <= is_boot;
            rd_acc_q <= acc;
        end
    end

    assign rd_word = rd_boot_q ? boot_rdata : flash_rdata_i;
    always_comb begin
        unique case (rd_acc_q)
            HBWLS_ACC_WORD: rd_lanes = swap_en ? {rd_word[7:0], rd_word[15:8]} : rd_word;
            HBWLS_ACC_EVEN: rd_lanes = HBWLS_PULLUP_BYTE | {8'h00, rd_word[7:0]};
            HBWLS_ACC_ODD: rd_lanes = HBWLS_PULLUP_BYTE | {8'h00, rd_word[15:8]};
            HBWLS_ACC_ILLEGAL: rd_lanes = HBWLS_PULLUP_BYTE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            host_rsp_o <= '0;
            host_data_oe_o <= 16'h0000;
        end else if (clk_en_i) begin
            host_rsp_o.valid <= rd_p_q;
            host_rsp_o.data <= rd_lanes;
            // upper lane never driven in 8-bit mode, pull-ups hold it high
            host_data_oe_o <= !rd_p_q ? 16'h0000 : (strap_q ? 16'hffff : 16'h00ff);
        end
    end

    // ==========================================================
    // register read port and sticky illegal-access flag
    logic illegal_q;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            illegal_q <= 1'b0;
        end else if (clk_en_i) begin
            if ((host_req_i.rd || host_req_i.wr) && acc == HBWLS_ACC_ILLEGAL) begin
                illegal_q <= 1'b1;
            end else if (reg_wr_i && reg_addr_i == HBWLS_STATUS_OFF && reg_wdata_i[HBWLS_ST_ILLEGAL_POS]) begin
                illegal_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (clk_en_i) begin
            reg_rdata_o <= HBWLS_UNMAPPED_RD;
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    HBWLS_ENDIAN_CTRL_OFF: reg_rdata_o <= {30'h0, endian_q};
                    HBWLS_STATUS_OFF: begin
                        reg_rdata_o <= {29'h0, strap_q, illegal_q, ready};
                    end
                    HBWLS_BOOT_WIN_OFF: reg_rdata_o <= 32'(BOOT_WORDS);
                    default: reg_rdata_o <= HBWLS_UNMAPPED_RD;
                endcase
            end
        end
    end
endmodule

//--- hbwls_pkg.sv
/*
 shared constants and carrier structs for the host bus width and lane steering block.
 assumes a single 200 MHz core clock and a plain register port.
*/
package hbwls_pkg;
    // ==========================================================
    // register map (word offsets are byte addresses)
    localparam logic [7:0] HBWLS_ENDIAN_CTRL_OFF = 8'h00;
    localparam logic [7:0] HBWLS_STATUS_OFF = 8'h04;
    localparam logic [7:0] HBWLS_BOOT_WIN_OFF = 8'h08;
    localparam int HBWLS_SWAP_LOW_POS = 0;
    localparam int HBWLS_SWAP_HIGH_POS = 1;
    localparam logic [1:0] HBWLS_ENDIAN_RST = 2'h0;
    localparam int HBWLS_ST_INIT_DONE_POS = 0;
    localparam int HBWLS_ST_ILLEGAL_POS = 1;
    localparam int HBWLS_ST_WIDTH_POS = 2;
    localparam logic [31:0] HBWLS_UNMAPPED_RD = 32'h0000_0000;
    // ==========================================================
    // timing and sizes
    localparam int HBWLS_CLK_MHZ = 200;
    localparam int HBWLS_BOOT_WORDS = 1024;
    localparam int HBWLS_PROT_WORDS = 16;
    localparam logic [15:0] HBWLS_PULLUP_BYTE = 16'hff00;
    // ==========================================================
    // carriers
    typedef enum logic [1:0] {
        HBWLS_ACC_WORD,
        HBWLS_ACC_EVEN,
        HBWLS_ACC_ODD,
        HBWLS_ACC_ILLEGAL
    } hbwls_acc_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [12:0] addr;
        logic [15:0] data;
    } hbwls_host_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } hbwls_host_rsp_s;
endpackage

//--- hbwls_mem.sv
/*
 small single-port memory with registered read data.
 assumes synchronous inputs on one clock.
*/
`timescale 1ns/1ps
module hbwls_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 1024,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic core_clk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [1:0] be_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    initial begin
        if (WIDTH != 16 || DEPTH < 2) begin
            $error("hbwls_mem: unsupported width or depth");
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (ce_i && we_i && be_i[0]) begin
            mem_q[addr_i][7:0] <= wdata_i[7:0];
        end
        if (ce_i && we_i && be_i[1]) begin
            mem_q[addr_i][15:8] <= wdata_i[15:8];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (ce_i) begin
            rdata_o <= mem_q[addr_i];
        end
    end
endmodule

//--- hbwls_top_sva.sv
/*
 checker for hbwls_top port timing.
 assumes clk_en_i and strap stay fixed between resets.
*/
`timescale 1ns/1ps
module hbwls_top_chk (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire hbwls_pkg::hbwls_host_req_s host_req_i,
    input wire logic bus_width_strap_i,
    input wire hbwls_pkg::hbwls_host_rsp_s host_rsp_o,
    input wire logic [15:0] host_data_oe_o,
    input wire logic init_pending_n_o,
    input wire logic load_req_o,
    input wire logic flash_rd_o,
    input wire logic flash_wr_o,
    input wire logic [12:0] flash_addr_o
);
    import hbwls_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // ==========================================================
    // sequences
    sequence s_live;
        clk_en_i && init_pending_n_o;
    endsequence
    sequence s_take;
        s_live ##0 host_req_i.rd && !(host_req_i.addr[0] && bus_width_strap_i);
    endsequence
    sequence s_bad;
        s_live ##0 host_req_i.addr[0] && bus_width_strap_i;
    endsequence
    // ==========================================================
    // assertions
    a_rd_two_cycles: assert property (s_take |-> ##2 host_rsp_o.valid)
        else $error("read answer not two cycles after request");
    a_bad_rd_silent: assert property (s_bad ##0 host_req_i.rd |-> ##2 !host_rsp_o.valid)
        else $error("illegal read answered");
    a_bad_wr_silent: assert property (s_bad ##0 host_req_i.wr |-> ##1 !flash_wr_o)
        else $error("illegal write reached flash");
    a_oe_word: assert property (host_rsp_o.valid && bus_width_strap_i |-> host_data_oe_o == 16'hffff)
        else $error("word mode enables wrong");
    a_oe_byte: assert property (host_rsp_o.valid && !bus_width_strap_i
        |-> host_data_oe_o == 16'h00ff && host_rsp_o.data[15:8] == 8'hff)
        else $error("byte mode upper lanes wrong");
    a_load_pend_low: assert property (load_req_o |-> !init_pending_n_o ##1 !init_pending_n_o)
        else $error("pending negated during load");
    a_pend_holds: assert property ($rose(init_pending_n_o) |=> init_pending_n_o [*8])
        else $error("pending reasserted after init");
    a_no_early_rsp: assert property (!init_pending_n_o |-> !host_rsp_o.valid && host_data_oe_o == 16'h0000)
        else $error("response before init done");
    a_flash_word: assert property (flash_rd_o || flash_wr_o |-> !flash_addr_o[0])
        else $error("flash address not word aligned");
endmodule

bind hbwls_top hbwls_top_chk i_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
    .host_req_i(host_req_i), .bus_width_strap_i(bus_width_strap_i), .host_rsp_o(host_rsp_o),
    .host_data_oe_o(host_data_oe_o), .init_pending_n_o(init_pending_n_o), .load_req_o(load_req_o),
    .flash_rd_o(flash_rd_o), .flash_wr_o(flash_wr_o), .flash_addr_o(flash_addr_o));

//--- hbwls_far_model.sv
/*
 init word source with random latency and a flash word store.
 assumes single clock; answers come by non-blocking update.
*/
`timescale 1ns/1ps
module hbwls_far_model (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic load_req_i,
    input wire logic [15:0] load_addr_i,
    output logic load_valid_o,
    output logic [15:0] load_data_o,
    input wire logic flash_rd_i,
    input wire logic flash_wr_i,
    input wire logic [12:0] flash_addr_i,
    input wire logic [15:0] flash_wdata_i,
    output logic [15:0] flash_rdata_o
);
    logic [15:0] mem [4096];
    logic [15:0] addr_q;
    logic [1:0] wait_q;
    logic busy_q;
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_q <= 1'b0;
            load_valid_o <= 1'b0;
            load_data_o <= 16'h0000;
        end else begin
            load_valid_o <= 1'b0;
            load_data_o <= ~load_data_o;
            if (load_req_i) begin
                addr_q <= load_addr_i;
                wait_q <= 2'($urandom_range(2, 0));
                busy_q <= 1'b1;
            end else if (busy_q && wait_q == 2'h0) begin
                load_valid_o <= 1'b1;
                load_data_o <= {addr_q[7:0] + 8'h11, ~addr_q[7:0]};
                busy_q <= 1'b0;
            end else if (busy_q) begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end
    // word stands only while the read strobe is high, noise otherwise
    logic [15:0] noise_q;
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            noise_q <= 16'h5a5a;
        end else begin
            noise_q <= ~noise_q;
        end
    end
    always @(posedge core_clk_i) begin
        if (flash_wr_i) begin
            mem[flash_addr_i[12:1]] <= flash_wdata_i;
        end
    end
    assign flash_rdata_o = flash_rd_i ? mem[flash_addr_i[12:1]] : noise_q;
endmodule

//--- tb_host_bus_width_lane_steering.sv
/*
 self-checking bench for hbwls_top.
 assumes hbwls_far_model as init source and flash.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_host_bus_width_lane_steering;
    import hbwls_pkg::*;
    localparam int BW = 4;
    localparam int PW = 2;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic strap = 1'b1;
    hbwls_host_req_s host_req = '0;
    hbwls_host_rsp_s host_rsp;
    logic [15:0] oe, load_addr, load_data, flash_wdata, flash_rdata;
    logic pend_n, load_req, load_valid, flash_rd, flash_wr, rd_seen = 1'b0;
    logic [12:0] flash_addr;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [PW*16-1:0] prot;
    int err_total = 0, cmp_count = 0, cyc = 0;
    logic [15:0] exp_q [$];
    logic [31:0] reg_q [$];
    logic [15:0] exp_h;
    logic [31:0] exp_r;
    logic [12:0] fa [4];
    logic [15:0] fd [4];
    always #2.5 core_clk_i = ~core_clk_i;
    hbwls_top #(.BOOT_WORDS(BW), .PROT_WORDS(PW)) i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .clk_en_i(1'b1), .host_req_i(host_req), .bus_width_strap_i(strap), .host_rsp_o(host_rsp),
        .host_data_oe_o(oe), .init_pending_n_o(pend_n), .load_req_o(load_req), .load_addr_o(load_addr),
        .load_valid_i(load_valid), .load_data_i(load_data), .flash_rd_o(flash_rd), .flash_wr_o(flash_wr),
        .flash_addr_o(flash_addr), .flash_wdata_o(flash_wdata), .flash_rdata_i(flash_rdata),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .prot_state_o(prot));
    hbwls_far_model i_far (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .load_req_i(load_req),
        .load_addr_i(load_addr), .load_valid_o(load_valid), .load_data_o(load_data), .flash_rd_i(flash_rd),
        .flash_wr_i(flash_wr), .flash_addr_i(flash_addr), .flash_wdata_i(flash_wdata),
        .flash_rdata_o(flash_rdata));
    function automatic logic [15:0] ld(input int a);
        return {8'(a) + 8'h11, ~8'(a)};
    endfunction
    function automatic logic [15:0] sw(input logic [15:0] x);
        return {x[7:0], x[15:8]};
    endfunction
    task automatic give_verdict();
        if (exp_q.size() != 0 || reg_q.size() != 0) begin
            err_total++;
            $display("BAD answers_left exp 0 got %0d", exp_q.size() + reg_q.size());
        end
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================================
    // drivers
    task automatic hreq(input logic rd, input logic [12:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        host_req <= '{rd: rd, wr: !rd, addr: a, data: d};
    endtask
    task automatic hrd(input logic [12:0] a, input logic [15:0] e);
        hreq(1'b1, a, 16'h0);
        exp_q.push_back(e);
    endtask
    task automatic hidle();
        @(posedge core_clk_i);
        host_req <= '0;
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic rwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk_i);
        reg_wr <= 1'b0;
    endtask
    task automatic rrd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        {reg_rd, reg_addr} <= {1'b1, a};
        reg_q.push_back(e);
        @(posedge core_clk_i);
        reg_rd <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic do_reset(input logic s);
        @(posedge core_clk_i);
        {resetn_i, strap} <= {1'b0, s};
        repeat (16) @(posedge core_clk_i);
        `CHK("pend_rst", 1'b0, pend_n)
        resetn_i <= 1'b1;
        hreq(1'b1, 13'h0, 16'h0);
        hidle();
        for (int i = 0; i < 300 && pend_n !== 1'b1; i++) @(posedge core_clk_i);
        `CHK("pend_done", 1'b1, pend_n)
        for (int i = 0; i < PW; i++) `CHK("prot", ld(BW + i), prot[i*16+:16])
    endtask
    // ==========================================================
    // monitor and watchdog
    always @(posedge core_clk_i) begin
        if (resetn_i && host_rsp.valid) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("BAD host_rsp exp none got %h", host_rsp.data);
            end else begin
                exp_h = exp_q.pop_front();
                `CHK("host_rsp", exp_h, host_rsp.data)
            end
        end
        if (rd_seen) begin
            exp_r = reg_q.pop_front();
            `CHK("reg_rdata", exp_r, reg_rdata)
        end
        rd_seen <= reg_rd;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    // ==========================================================
    // tests
    initial begin
        void'($urandom(32'h3b9239da));
        do_reset(1'b1);
        for (int k = 0; k < BW; k++) hrd(13'(k * 2), ld(k));
        hidle();
        rrd(HBWLS_STATUS_OFF, 32'h5);
        rrd(8'h10, HBWLS_UNMAPPED_RD);
        $display("test word reads done");
        rwr(HBWLS_ENDIAN_CTRL_OFF, 32'h3);
        rrd(HBWLS_ENDIAN_CTRL_OFF, 32'h3);
        hreq(1'b0, 13'h2, 16'hbeef);
        hidle();
        hrd(13'h2, 16'hbeef);
        hrd(13'h0, sw(ld(0)));
        hidle();
        rwr(HBWLS_ENDIAN_CTRL_OFF, 32'h1);
        hrd(13'h2, 16'hefbe);
        hidle();
        rwr(HBWLS_ENDIAN_CTRL_OFF, 32'h0);
        $display("test swap done");
        for (int i = 0; i < 4; i++) begin
            fa[i] = 13'h1000 | 13'(i << 9) | (13'($urandom) & 13'h1fe);
            fd[i] = 16'($urandom);
            hreq(1'b0, fa[i], fd[i]);
        end
        hidle();
        for (int i = 0; i < 4; i++) hrd(fa[i], fd[i]);
        hidle();
        $display("test flash done");
        hreq(1'b1, 13'h1, 16'h0);
        hreq(1'b0, 13'h3, 16'h1234);
        hreq(1'b0, fa[0] | 13'h1, 16'h5678);
        hidle();
        hrd(13'h2, 16'hefbe);
        hrd(fa[0], fd[0]);
        hidle();
        rrd(HBWLS_STATUS_OFF, 32'h7);
        rwr(HBWLS_STATUS_OFF, 32'h2);
        rrd(HBWLS_STATUS_OFF, 32'h5);
        $display("test illegal done");
        do_reset(1'b0);
        for (int k = 0; k < BW; k++) begin
            hrd(13'(k * 2), {8'hff, 8'(ld(k))});
            hrd(13'(k * 2 + 1), {8'hff, 8'(ld(k) >> 8)});
        end
        hidle();
        rrd(HBWLS_STATUS_OFF, 32'h1);
        $display("test byte mode done");
        repeat (2) @(posedge core_clk_i);
        give_verdict();
    end
endmodule
